// ---- qcjl_top.sv ----
// Quarter coupling, carry ring, jump condition and predict interlock.
// Assumes an Avalon-MM master and a datapath that samples outputs each cycle.
//
// Contract
// RL1 - Left inter-quarter coupling ignores cycle class
// RL2 - Cycle class left shift couples bit 8 to 9
// RL3 - Non-sign quarters couple bit 8 to 9
// RL4 - Quarter 4 bit 9 always a sign bit
// RL5 - Paired class: second accumulator always couples 8 to 9
// RL6 - Non-divide carries circulate in fracture ring
// RL7 - Divide end-around adds one on negative operand
// RL8 - Positive non-zero active subword raises jump level
// RL9 - Negative non-zero active subword raises jump level
// RL10 - Sign quarter overflow raises jump level
// RL11 - Jump level is OR of all terms
// RL12 - Non-zero means some quarter not uniform
// RL13 - Overflow flags tested only in sign quarters
// RL14 - Clear interlock at event before sequencer end
// RL15 - Remaining time after predict at most 2.8 us
// RL16 - Normalize shifts until two leading bits differ
// RL17 - Config bits 7-4 activity, 9-8 fracture
// RL18 - No 8-to-9 coupling into preserved sign bit
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module qcjl_top #(
   parameter int unsigned SEQ_CYCLES = qcjl_pkg::SEQ_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Datapath state
   input  wire logic [35:0] a_word_i,
   input  wire logic [35:0] b_word_i,
   input  wire logic [3:0]  ovf_flag_i,
   input  wire logic [3:0]  operand_sign_i,
   input  wire logic [3:0]  quarter_carry_out_i,
   // Coupling results
   output logic      [3:0]  a_couple89_o,
   output logic      [3:0]  b_couple89_o,
   output logic      [3:0]  a_shl_in_o,
   output logic      [3:0]  b_shl_in_o,
   output logic      [3:0]  quarter_carry_in_o,
   output logic      [3:0]  norm_shift_o,
   // Jump and interlock levels
   output logic             jump_condition_level_o,
   output logic             arith_predict_interlock_o
);
   localparam int unsigned CW = qcjl_pkg::CNT_W;
   localparam logic [CW-1:0] SEQ_LOAD = CW'(SEQ_CYCLES);
   localparam logic [CW-1:0] PRED_CYC = CW'(qcjl_pkg::PREDICT_CYC);

   // Bit 9 of quarter q
   function automatic logic qbit9(input logic [35:0] w, input int q);
      qbit9 = w[q*9+8];
   endfunction

   // Bit 8 of quarter q
   function automatic logic qbit8(input logic [35:0] w, input int q);
      qbit8 = w[q*9+7];
   endfunction

   // Quarter is all zeros or all ones
   function automatic logic qflat(input logic [35:0] w, input int q);
      logic [8:0] v;
      v = w[q*9 +: 9];
      qflat = (v == 9'h000) || (v == 9'h1ff);
   endfunction

   logic [9:0] config_bits_register;
   logic [8:0] ctrl;
   logic       start_pulse;

   logic cycle_class;
   logic paired_accumulator_class;
   logic divide;
   logic shl;
   logic jump_on_positive;
   logic jump_on_negative;
   logic jump_on_overflow;
   logic add_op;
   logic normalize;

   assign cycle_class              = ctrl[qcjl_pkg::CT_CYCLE];
   assign paired_accumulator_class = ctrl[qcjl_pkg::CT_PAIRED];
   assign divide                   = ctrl[qcjl_pkg::CT_DIVIDE];
   assign shl                      = ctrl[qcjl_pkg::CT_SHL];
   assign jump_on_positive         = ctrl[qcjl_pkg::CT_JPOS];
   assign jump_on_negative         = ctrl[qcjl_pkg::CT_JNEG];
   assign jump_on_overflow         = ctrl[qcjl_pkg::CT_JOVF];
   assign add_op                   = ctrl[qcjl_pkg::CT_ADD];
   assign normalize                = ctrl[qcjl_pkg::CT_NORM];

   // Fracture decode
   qcjl_frac_if fi ();

   assign fi.frac   = qcjl_pkg::qcjl_frac_t'(config_bits_register[9:8]); // RL17
   assign fi.act_cf = config_bits_register[7:4]; // RL17

   qcjl_decode u_decode (
      .fi (fi.dec)
   );

   // Bus handshake
   logic        bus_req;
   logic        bus_commit;
   logic [31:0] rd_mux;

   assign bus_req    = avs_read_i || avs_write_i;
   assign bus_commit = bus_req && !avs_waitrequest_o;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (bus_req && avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= rd_mux;
      end
   end

   // Configuration and control registers
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         config_bits_register <= qcjl_pkg::CONFIG_RST;
      end else if (bus_commit && avs_write_i
                   && avs_address_i == qcjl_pkg::OFS_CONFIG) begin
         if (avs_byteenable_i[0]) begin
            config_bits_register[7:0] <= avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            config_bits_register[9:8] <= avs_writedata_i[9:8];
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl        <= qcjl_pkg::CTRL_RST;
         start_pulse <= 1'b0;
      end else begin
         start_pulse <= 1'b0;
         if (bus_commit && avs_write_i
             && avs_address_i == qcjl_pkg::OFS_CTRL) begin
            if (avs_byteenable_i[0]) begin
               ctrl[7:0] <= avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
               ctrl[8]     <= avs_writedata_i[8];
               start_pulse <= avs_writedata_i[qcjl_pkg::CT_START];
            end
         end
      end
   end

   // Coupling, carry, jump and normalize terms
   logic [3:0] next_a_couple;
   logic [3:0] next_b_couple;
   logic [3:0] next_a_shl;
   logic [3:0] next_b_shl;
   logic [3:0] next_cyi;
   logic [3:0] next_norm;
   logic       next_jump;
   logic       norm_near;

   always_comb begin
      int s;
      logic nz;
      s             = 0;
      nz            = 1'b0;
      next_a_couple = 4'h0;
      next_b_couple = 4'h0;
      next_a_shl    = 4'h0;
      next_b_shl    = 4'h0;
      next_cyi      = 4'h0;
      next_norm     = 4'h0;
      next_jump     = 1'b0;
      norm_near     = 1'b1;
      for (int q = 0; q < 4; q++) begin
         s = int'(fi.owner[q]);
         // Intra-quarter 8 to 9 coupling; sign bits kept unless cycling, or for b unless paired
         if (shl) begin
            next_a_couple[q] = cycle_class || !fi.sign_q[q]; // RL2 RL3 RL4 RL18
            next_b_couple[q] = cycle_class || !fi.sign_q[q]
                               || paired_accumulator_class; // RL5 RL18
         end
         // Inter-quarter left shift; cycle class plays no part
         if (!fi.low_q[q]) begin
            next_a_shl[q] = qbit9(a_word_i, q - 1); // RL1
            next_b_shl[q] = qbit9(b_word_i, q - 1); // RL1
         end else if (paired_accumulator_class) begin
            next_a_shl[q] = qbit9(b_word_i, s); // RL1
            next_b_shl[q] = qbit9(a_word_i, s); // RL1
         end else begin
            next_a_shl[q] = qbit9(a_word_i, s); // RL1
            next_b_shl[q] = qbit9(b_word_i, s); // RL1
         end
         if (!shl) begin
            next_a_shl[q] = 1'b0;
            next_b_shl[q] = 1'b0;
         end
         // Carry ring; only the end-around carry changes for divide
         if (!fi.low_q[q]) begin
            next_cyi[q] = quarter_carry_out_i[q-1]; // RL6 RL7
         end else if (divide) begin
            next_cyi[q] = operand_sign_i[s]; // RL7
         end else begin
            next_cyi[q] = quarter_carry_out_i[s]; // RL6
         end
      end
      for (int k = 0; k < 4; k++) begin
         if (fi.sub_act[k]) begin
            nz = 1'b0;
            for (int m = 0; m < 4; m++) begin
               if (int'(fi.owner[m]) == k && !qflat(a_word_i, m)) begin
                  nz = 1'b1; // RL12
               end
            end
            if (jump_on_positive && nz && !qbit9(a_word_i, k)) begin
               next_jump = 1'b1; // RL8 RL11
            end
            if (jump_on_negative && nz && qbit9(a_word_i, k)) begin
               next_jump = 1'b1; // RL9 RL11
            end
            if (jump_on_overflow && ovf_flag_i[k]) begin
               next_jump = 1'b1; // RL10 RL11 RL13
            end
            // Normalize continues while the two leading bits agree
            if (normalize && qbit9(a_word_i, k) == qbit8(a_word_i, k)) begin
               for (int m = 0; m < 4; m++) begin
                  if (int'(fi.owner[m]) == k) begin
                     next_norm[m] = 1'b1; // RL16
                  end
               end
            end
            // A non-flat sign quarter finishes within eight shifts
            if (qflat(a_word_i, k)) begin
               norm_near = 1'b0; // RL16
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         a_couple89_o       <= 4'h0;
         b_couple89_o       <= 4'h0;
         a_shl_in_o         <= 4'h0;
         b_shl_in_o         <= 4'h0;
         quarter_carry_in_o <= 4'h0;
      end else begin
         a_couple89_o       <= next_a_couple;
         b_couple89_o       <= next_b_couple;
         a_shl_in_o         <= next_a_shl;
         b_shl_in_o         <= next_b_shl;
         quarter_carry_in_o <= next_cyi;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         jump_condition_level_o <= 1'b0;
         norm_shift_o           <= 4'h0;
      end else begin
         jump_condition_level_o <= next_jump;
         norm_shift_o           <= next_norm;
      end
   end

   // Sequencer tracking and predict interlock
   qcjl_pkg::qcjl_seq_t seq;
   qcjl_pkg::qcjl_seq_t next_seq;
   logic [CW-1:0]       seq_left;
   logic                predict_evt;
   logic                seq_end;

   // Normalize predicts on data; others on remaining time
   assign predict_evt = normalize ? norm_near
                                  : (seq_left <= PRED_CYC); // RL14 RL15
   assign seq_end     = normalize ? (next_norm == 4'h0)
                                  : (seq_left == '0);

   always_comb begin
      next_seq = seq;
      unique case (seq)
         qcjl_pkg::SEQ_IDLE: begin
            if (start_pulse) begin
               next_seq = qcjl_pkg::SEQ_RUN;
            end
         end
         qcjl_pkg::SEQ_RUN: begin
            if (predict_evt) begin
               next_seq = qcjl_pkg::SEQ_TAIL; // RL14
            end
         end
         qcjl_pkg::SEQ_TAIL: begin
            if (seq_end) begin
               next_seq = qcjl_pkg::SEQ_IDLE;
            end
         end
         default: next_seq = qcjl_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seq <= qcjl_pkg::SEQ_IDLE;
      end else begin
         seq <= next_seq;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seq_left <= '0;
      end else if (seq == qcjl_pkg::SEQ_IDLE && start_pulse) begin
         seq_left <= SEQ_LOAD;
      end else if (seq_left != '0) begin
         seq_left <= seq_left - CW'(1);
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         arith_predict_interlock_o <= 1'b0;
      end else if (next_seq == qcjl_pkg::SEQ_RUN) begin
         arith_predict_interlock_o <= 1'b1;
      end else begin
         arith_predict_interlock_o <= 1'b0; // RL14
      end
   end

   // Read data
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_i)
         qcjl_pkg::OFS_CONFIG: rd_mux[9:0] = config_bits_register;
         qcjl_pkg::OFS_CTRL:   rd_mux[8:0] = ctrl;
         qcjl_pkg::OFS_STATUS: begin
            rd_mux[0]    = jump_condition_level_o;
            rd_mux[1]    = arith_predict_interlock_o;
            rd_mux[3:2]  = seq;
            rd_mux[7:4]  = norm_shift_o;
            rd_mux[11:8] = fi.sub_act;
            rd_mux[15:12] = fi.sign_q;
            rd_mux[16]   = add_op;
         end
         qcjl_pkg::OFS_COUPLE: begin
            rd_mux[3:0]   = a_couple89_o;
            rd_mux[7:4]   = b_couple89_o;
            rd_mux[11:8]  = quarter_carry_in_o;
            rd_mux[15:12] = a_shl_in_o;
            rd_mux[19:16] = b_shl_in_o;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

// ---- qcjl_pkg.sv ----
// Constants for the quarter coupling and jump logic block.
// Assumes a 100 MHz clock and a 4-bit byte address Avalon-MM slave.
package qcjl_pkg;
   // Geometry
   localparam int unsigned QN = 4;
   localparam int unsigned QW = 9;
   localparam int unsigned WW = QN * QW;
   // Register byte offsets
   localparam logic [3:0] OFS_CONFIG = 4'h0;
   localparam logic [3:0] OFS_CTRL   = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_COUPLE = 4'hc;
   // Configuration field positions
   localparam int unsigned CF_ACT_LO  = 4;
   localparam int unsigned CF_FRAC_LO = 8;
   localparam int unsigned CF_W       = 10;
   localparam logic [9:0]  CONFIG_RST = 10'h000;
   // Control bit positions
   localparam int unsigned CT_CYCLE  = 0;
   localparam int unsigned CT_PAIRED = 1;
   localparam int unsigned CT_DIVIDE = 2;
   localparam int unsigned CT_SHL    = 3;
   localparam int unsigned CT_JPOS   = 4;
   localparam int unsigned CT_JNEG   = 5;
   localparam int unsigned CT_JOVF   = 6;
   localparam int unsigned CT_ADD    = 7;
   localparam int unsigned CT_NORM   = 8;
   localparam int unsigned CT_START  = 9;
   localparam int unsigned CT_W      = 9;
   localparam logic [8:0]  CTRL_RST  = 9'h000;
   // Timing
   localparam int unsigned CLK_NS          = 10;
   localparam int unsigned PREDICT_NS      = 2800;
   localparam int unsigned PREDICT_CYC     = PREDICT_NS / CLK_NS;
   localparam int unsigned SEQ_CYCLES_DEF  = 600;
   localparam int unsigned NORM_MAX_SHIFTS = 8;
   localparam int unsigned CNT_W           = 16;
   // Fracture codes
   typedef enum logic [1:0] {
      FRAC_36   = 2'h0,
      FRAC_18   = 2'h1,
      FRAC_27_9 = 2'h2,
      FRAC_9X4  = 2'h3
   } qcjl_frac_t;
   // Sequencer tracking states
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RUN  = 2'b01,
      SEQ_TAIL = 2'b11
   } qcjl_seq_t;
endpackage

// ---- qcjl_frac_if.sv ----
// Fracture decode signals between the top and its decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface qcjl_frac_if;
   qcjl_pkg::qcjl_frac_t frac;
   logic [3:0]           act_cf;
   logic [3:0]           sign_q;
   logic [3:0]           low_q;
   logic [3:0]           sub_act;
   logic [1:0]           owner [4];
   modport dec (input frac, act_cf, output sign_q, low_q, sub_act, owner);
   modport use_ (output frac, act_cf, input sign_q, low_q, sub_act, owner);
endinterface
`default_nettype wire

// ---- qcjl_decode.sv ----
// Fracture and activity decoder: sign quarters, subword owners, activity.
// Assumes configuration levels are stable register outputs.
`timescale 1ns/10ps
`default_nettype none
module qcjl_decode (
   qcjl_frac_if.dec fi
);
   logic [3:0] act;
   logic [3:0] sign;

   // A quarter is active when its configuration bit is zero
   assign act = ~fi.act_cf; // RL17

   always_comb begin
      unique case (fi.frac) // RL17
         qcjl_pkg::FRAC_36:   sign = 4'h8;
         qcjl_pkg::FRAC_18:   sign = 4'ha;
         qcjl_pkg::FRAC_27_9: sign = 4'h9;
         qcjl_pkg::FRAC_9X4:  sign = 4'hf;
      endcase
   end
   assign fi.sign_q = sign;

   genvar q;
   generate
      for (q = 0; q < 4; q++) begin : g_q
         // Owner is the nearest sign quarter at or above this quarter
         always_comb begin
            fi.owner[q] = 2'h3;
            for (int s = 3; s >= q; s--) begin
               if (sign[s]) begin
                  fi.owner[q] = 2'(s);
               end
            end
         end
         if (q == 0) begin : g_low0
            assign fi.low_q[q] = 1'b1;
         end else begin : g_lown
            assign fi.low_q[q] = sign[q-1];
         end
         always_comb begin
            fi.sub_act[q] = 1'b0;
            for (int m = 0; m < 4; m++) begin
               if (fi.owner[m] == 2'(q) && act[m]) begin
                  fi.sub_act[q] = sign[q];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- qcjl_monitor.sv ----
// Checker for the coupling, carry, jump and interlock outputs of the top.
// Assumes one-cycle registered outputs and the package register map.
`timescale 1ns/10ps
`default_nettype none
module qcjl_monitor #(
   parameter int unsigned SEQ_CYCLES = 600
) (
   input wire logic        clock_i,
   input wire logic        arst_n_i,
   input wire logic [3:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic        avs_waitrequest_o,
   input wire logic [3:0]  ovf_flag_i,
   input wire logic [3:0]  operand_sign_i,
   input wire logic [3:0]  quarter_carry_out_i,
   input wire logic [3:0]  a_couple89_o,
   input wire logic [3:0]  b_couple89_o,
   input wire logic [3:0]  quarter_carry_in_o,
   input wire logic        jump_condition_level_o,
   input wire logic        arith_predict_interlock_o
);
   localparam int LO = int'(SEQ_CYCLES) - 285;
   localparam int HI = int'(SEQ_CYCLES) - 275;
   logic [9:0] cfg;
   logic [8:0] ctl;
   logic [8:0] p_ctl;
   logic [3:0] p_sm, p_live, p_co, p_os, p_ovf;
   logic [1:0] p_frac;
   int         hi_cnt;
   wire logic  cmt = avs_write_i && !avs_waitrequest_o;
   // Sign quarters of subwords that hold an active quarter
   function automatic logic [3:0] live(input logic [1:0] f, input logic [3:0] a);
      case (f)
         2'h0: return {|a, 3'h0};
         2'h1: return {|a[3:2], 1'b0, |a[1:0], 1'b0};
         2'h2: return {|a[3:1], 2'h0, a[0]};
         default: return a;
      endcase
   endfunction
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg <= 10'h000;
         ctl <= 9'h000;
      end else if (cmt && avs_address_i == qcjl_pkg::OFS_CONFIG) begin
         if (avs_byteenable_i[0]) cfg[7:0] <= avs_writedata_i[7:0];
         if (avs_byteenable_i[1]) cfg[9:8] <= avs_writedata_i[9:8];
      end else if (cmt && avs_address_i == qcjl_pkg::OFS_CTRL) begin
         if (avs_byteenable_i[0]) ctl[7:0] <= avs_writedata_i[7:0];
         if (avs_byteenable_i[1]) ctl[8] <= avs_writedata_i[8];
      end
   end
   // One cycle old, as the outputs lag
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {p_ctl, p_sm, p_live, p_co, p_os, p_ovf, p_frac} <= '0;
      end else begin
         p_ctl  <= ctl;
         p_frac <= cfg[9:8];
         p_sm   <= live(cfg[9:8], 4'hf);
         p_live <= live(cfg[9:8], ~cfg[7:4]);
         p_co   <= quarter_carry_out_i;
         p_os   <= operand_sign_i;
         p_ovf  <= ovf_flag_i;
      end
   end
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) hi_cnt <= 0;
      else hi_cnt <= arith_predict_interlock_o ? hi_cnt + 1 : 0;
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!arst_n_i);
   a_wait_pulse: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("access not answered");
   a_q4_sign: assert property (a_couple89_o[3] |-> p_ctl[0])
      else $error("quarter 4 sign bit coupled");
   a_cycle_all: assert property (p_ctl[3] && p_ctl[0] |-> a_couple89_o == 4'hf)
      else $error("cycle class coupling missing");
   a_paired_b: assert property (p_ctl[3] && p_ctl[1] |-> b_couple89_o == 4'hf)
      else $error("second register coupling missing");
   a_sign_keep: assert property (p_ctl[3] && !p_ctl[0] |-> a_couple89_o == ~p_sm)
      else $error("sign bit coupling wrong");
   a_carry_ring: assert property (!p_ctl[2] && p_frac == 2'h0 |->
      quarter_carry_in_o == {p_co[2:0], p_co[3]}) else $error("carry ring wrong");
   a_div_carry: assert property (p_ctl[2] && p_frac == 2'h0 |->
      quarter_carry_in_o == {p_co[2:0], p_os[3]}) else $error("divide carry wrong");
   a_ovf_jump: assert property (p_ctl[6:4] == 3'b100 |->
      jump_condition_level_o == |(p_ovf & p_live)) else $error("overflow jump wrong");
   a_no_jump: assert property (p_ctl[6:4] == 3'b000 |-> !jump_condition_level_o)
      else $error("jump level without jump");
   a_predict_end: assert property ($fell(arith_predict_interlock_o) && !ctl[8] |->
      hi_cnt >= LO && hi_cnt <= HI) else $error("interlock span wrong");
   a_predict_max: assert property (arith_predict_interlock_o && !ctl[8] |-> hi_cnt <= HI)
      else $error("interlock held too long");
   c_cycle: cover property (p_ctl[3] && p_ctl[0]);
   c_div: cover property (p_ctl[2]);
   c_predict: cover property ($fell(arith_predict_interlock_o));
endmodule
bind qcjl_top qcjl_monitor #(.SEQ_CYCLES(SEQ_CYCLES)) i_mon (
   .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
   .ovf_flag_i(ovf_flag_i), .operand_sign_i(operand_sign_i),
   .quarter_carry_out_i(quarter_carry_out_i), .a_couple89_o(a_couple89_o),
   .b_couple89_o(b_couple89_o), .quarter_carry_in_o(quarter_carry_in_o),
   .jump_condition_level_o(jump_condition_level_o),
   .arith_predict_interlock_o(arith_predict_interlock_o)
);
`default_nettype wire

// ---- qcjl_dp_model.sv ----
// Datapath stand-in presenting operand words, flags and carries.
// Assumes the bench changes the wanted values just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module qcjl_dp_model (
   // Wanted values
   input  wire logic [35:0] a_set_i,
   input  wire logic [11:0] flag_set_i,
   // Datapath state
   output logic      [35:0] a_word_o,
   output logic      [35:0] b_word_o,
   output logic      [3:0]  ovf_flag_o,
   output logic      [3:0]  operand_sign_o,
   output logic      [3:0]  carry_out_o
);
   assign a_word_o = a_set_i;
   // Second register holds the halves swapped so it differs from the first
   assign b_word_o = {a_set_i[17:0], a_set_i[35:18]};
   assign {ovf_flag_o, operand_sign_o, carry_out_o} = flag_set_i;
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the quarter coupling and jump block.
// Assumes a 100 MHz clock and one-cycle output latency.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int unsigned SEQ = 300;
   localparam logic [3:0] SM [4] = '{4'h7, 4'h5, 4'h6, 4'h0};
   logic        clock_i;
   logic        arst_n_i;
   logic [3:0]  adr;
   logic        rd_s, wr_s, wreq, jump, ilk;
   logic [31:0] wdat, rdat, v;
   logic [35:0] a_set, a_w, b_w;
   logic [11:0] fl_set;
   logic [3:0]  ovf, os, co, ac, bc, ash, bsh, cin, ns;
   int          n_fail;
   int          check_count;
   int          k;
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   qcjl_dp_model i_dp (
      .a_set_i(a_set), .flag_set_i(fl_set), .a_word_o(a_w), .b_word_o(b_w),
      .ovf_flag_o(ovf), .operand_sign_o(os), .carry_out_o(co)
   );
   qcjl_top #(.SEQ_CYCLES(SEQ)) i_dut (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd_s),
      .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .a_word_i(a_w), .b_word_i(b_w),
      .ovf_flag_i(ovf), .operand_sign_i(os), .quarter_carry_out_i(co),
      .a_couple89_o(ac), .b_couple89_o(bc), .a_shl_in_o(ash), .b_shl_in_o(bsh),
      .quarter_carry_in_o(cin), .norm_shift_o(ns), .jump_condition_level_o(jump),
      .arith_predict_interlock_o(ilk)
   );
   task automatic results;
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus access; read data lands in v
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      adr <= a;
      wdat <= d;
      wr_s <= w;
      rd_s <= !w;
      do @(posedge clock_i); while (wreq !== 1'b0);
      v = rdat;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic put(input logic [9:0] cf, input logic [9:0] ct, input logic [35:0] a,
                      input logic [11:0] f);
      acc(1'b1, qcjl_pkg::OFS_CONFIG, {22'h0, cf});
      acc(1'b1, qcjl_pkg::OFS_CTRL, {22'h0, ct});
      a_set <= a;
      fl_set <= f;
      repeat (2) @(posedge clock_i);
   endtask
   task automatic jc(input logic [9:0] cf, input logic [9:0] ct, input logic [35:0] a,
                     input logic [3:0] f, input logic e);
      put(cf, ct, a, {f, 8'h00});
      chk(32'(jump), 32'(e));
   endtask
   initial begin
      #200000;
      n_fail++;
      $display("Error at %0t: timeout", $time);
      results;
   end
   initial begin
      n_fail = 0;
      check_count = 0;
      arst_n_i = 1'b0;
      {adr, rd_s, wr_s, wdat, a_set, fl_set} = '0;
      repeat (20) @(posedge clock_i);
      chk(32'({wreq, jump, ilk}), 32'h4);
      arst_n_i <= 1'b1;
      @(posedge clock_i);
      acc(1'b0, qcjl_pkg::OFS_CTRL, 32'h0);
      chk(v, 32'h0);
      acc(1'b1, 4'h2, 32'hffff_ffff);
      acc(1'b0, 4'h2, 32'h0);
      chk(v, 32'h0);
      acc(1'b0, qcjl_pkg::OFS_CONFIG, 32'h0);
      chk(v, 32'h0);
      for (k = 0; k < 4; k++) begin
         put({k[1:0], 8'h00}, 10'h008, 36'h8_0000_0100, 12'h0);
         chk(32'(ac), 32'(SM[k]));
         chk(32'(bc), 32'(SM[k]));
         if (k == 0) chk(32'({bsh, ash}), 32'hc3);
         put({k[1:0], 8'h00}, 10'h009, 36'h8_0000_0100, 12'h0);
         chk(32'(ac), 32'hf);
         if (k == 0) chk(32'({bsh, ash}), 32'hc3);
         put({k[1:0], 8'h00}, 10'h00a, 36'h8_0000_0100, 12'h0);
         chk(32'(bc), 32'hf);
         chk(32'(ac[3]), 32'h0);
         acc(1'b0, qcjl_pkg::OFS_CONFIG, 32'h0);
         chk(32'(v[9:0]), 32'({k[1:0], 8'h00}));
      end
      jc(10'h100, 10'h010, 36'h0_0000_0001, 4'h0, 1'b1);
      jc(10'h100, 10'h020, 36'h0_0000_0001, 4'h0, 1'b0);
      jc(10'h100, 10'h010, 36'h0_0000_0000, 4'h0, 1'b0);
      jc(10'h100, 10'h020, 36'h0_0003_ffff, 4'h0, 1'b0);
      jc(10'h100, 10'h020, 36'h8_0004_0000, 4'h0, 1'b1);
      jc(10'h1c0, 10'h020, 36'h8_0004_0000, 4'h0, 1'b0);
      jc(10'h100, 10'h030, 36'h8_0004_0000, 4'h0, 1'b1);
      jc(10'h000, 10'h040, 36'h0, 4'h1, 1'b0);
      jc(10'h000, 10'h040, 36'h0, 4'h8, 1'b1);
      jc(10'h200, 10'h040, 36'h0, 4'h1, 1'b1);
      jc(10'h100, 10'h040, 36'h0, 4'h2, 1'b1);
      put(10'h000, 10'h000, 36'h0, 12'h007);
      chk(32'(cin), 32'he);
      put(10'h100, 10'h000, 36'h0, 12'h001);
      chk(32'(cin), 32'h2);
      put(10'h300, 10'h000, 36'h0, 12'h005);
      chk(32'(cin), 32'h5);
      put(10'h000, 10'h004, 36'h0, 12'h087);
      chk(32'(cin), 32'hf);
      put(10'h000, 10'h004, 36'h0, 12'h007);
      chk(32'(cin), 32'he);
      put(10'h000, 10'h100, 36'h0_0800_0000, 12'h0);
      chk(32'(ns[3]), 32'h1);
      put(10'h000, 10'h100, 36'h4_0000_0000, 12'h0);
      chk(32'(ns[3]), 32'h0);
      acc(1'b1, qcjl_pkg::OFS_CTRL, 32'h300);
      @(posedge clock_i);
      chk(32'(ilk), 32'h1);
      @(posedge clock_i);
      chk(32'(ilk), 32'h0);
      put(10'h000, 10'h080, 36'h0, 12'h0);
      acc(1'b1, qcjl_pkg::OFS_CTRL, 32'h280);
      k = 0;
      while (ilk !== 1'b1 && k < 10) begin
         @(posedge clock_i);
         k++;
      end
      k = 0;
      while (ilk === 1'b1 && k < SEQ) begin
         @(posedge clock_i);
         k++;
      end
      chk(32'(k >= SEQ - 285 && k <= SEQ - 275), 32'h1);
      results;
   end
endmodule
`default_nettype wire
